// ===== include/bri_readout_map.vh
/*
 * Constants for the barometer readout: bus addresses, command bytes,
 * bit counts and conversion timing.
 * Assumes it is included by bare name from the design files.
 */
`ifndef BRI_READOUT_MAP_VH
`define BRI_READOUT_MAP_VH

// Write and read forms of the target address.
`define BRI_ADDR_WR 8'hee
`define BRI_ADDR_RD 8'hef

// First command byte, all ones.
`define BRI_CMD_PREFIX 8'hff
// Select bytes for the two conversion kinds.
`define BRI_SEL_PRESSURE 8'hf0
`define BRI_SEL_TEMPERATURE 8'he8
// Readback pointer byte.
`define BRI_CMD_READBACK 8'hfd

// Bits in a byte and the index of the last transmitted bit.
`define BRI_BYTE_BITS 4'h8
`define BRI_LAST_TX_BIT 4'h7
// Result layout: high byte goes out first.
`define BRI_HI_MSB 15
`define BRI_HI_LSB 8
`define BRI_LO_MSB 7
`define BRI_LO_LSB 0

// Longest conversion time in milliseconds and master clock rate in Hz.
`define BRI_CONV_MS 35
`define BRI_MCLK_HZ 32768
// Master clock edges in the longest conversion, rounded down.
`define BRI_CONV_EDGES ((`BRI_CONV_MS * `BRI_MCLK_HZ) / 1000)

`endif

// ===== hw/bri_conv.v
/*
 * Conversion sequencer of the barometer readout. It times a conversion
 * in master clock edges and then latches the selected 16-bit sample.
 * Assumes the master clock edge pulse and the clear level come already
 * synchronised to i_clk, and the samples are stable on i_clk.
 */
`timescale 1ns/1ps
`include "bri_readout_map.vh"

module bri_conv #(
    parameter WIDTH = 16,
    parameter CONV_EDGES = `BRI_CONV_EDGES
) (
    input wire i_clk,
    input wire i_resetn,
    input wire i_mclk_rise,
    input wire i_clear_n,
    input wire i_start,
    input wire i_select_temp,
    input wire [WIDTH-1:0] i_pressure_sample,
    input wire [WIDTH-1:0] i_temperature_sample,
    output reg [WIDTH-1:0] o_result,
    output reg o_busy,
    output reg o_power_down
);
    // Index of the last edge, cut to the counter width on purpose.
    localparam integer EDGE_LAST_FULL = CONV_EDGES - 1;
    localparam [11:0] EDGE_LAST = EDGE_LAST_FULL[11:0];

    reg [11:0] edge_count; // Master clock edges seen in this conversion.
    reg select_temp; // Kind of the conversion under way.

    // The sequencer runs only while the clear input is high; low clear
    // holds it in reset but keeps the last result for readback.
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_result <= {WIDTH{1'b0}};
            o_busy <= 1'b0;
            o_power_down <= 1'b1;
            edge_count <= 12'h000;
            select_temp <= 1'b0;
        end else if (!i_clear_n) begin
            // Converter held in reset: abort and power down.
            o_busy <= 1'b0;
            o_power_down <= 1'b1;
            edge_count <= 12'h000;
        end else if (!o_busy) begin
            if (i_start) begin
                // Command accepted: wake up and start timing.
                o_busy <= 1'b1;
                o_power_down <= 1'b0;
                edge_count <= 12'h000;
                select_temp <= i_select_temp;
            end else begin
                o_power_down <= 1'b1;
            end
        end else if (i_mclk_rise) begin
            if (edge_count == EDGE_LAST) begin
                // Conversion done: one 16-bit word of either kind.
                o_result <= select_temp ? i_temperature_sample :
                    i_pressure_sample;
                o_busy <= 1'b0;
                o_power_down <= 1'b1;
            end else begin
                edge_count <= edge_count + 12'h001;
            end
        end
    end
endmodule // bri_conv

// ===== hw/bri_readout.v
/*
 * Barometer readout top: an I2C target that accepts conversion
 * commands and returns the 16-bit result, plus the conversion sequencer.
 * Assumes SCL, SDA, the master clock and the clear pin are asynchronous
 * to i_clk; SDA is open drain and resolved outside from o_sda_oe.
 */
`timescale 1ns/1ps
`include "bri_readout_map.vh"

// Behaviour
// - Answer write address ee, read ef.
// - Prefix ff then select f0/e8 starts conversion.
// - Pointer fd, restart, read high then low.
// - Acknowledge address and command bytes low.
// - Shift result bytes out MSB first.
// - Result is one 16-bit word.
// - Clear low holds converter in reset.
// - Power down automatically when idle.
module bri_readout #(
    parameter WIDTH = 16,
    parameter CONV_EDGES = `BRI_CONV_EDGES
) (
    input wire i_clk,
    input wire i_resetn,
    input wire i_scl,
    input wire i_sda,
    input wire i_mclk,
    input wire i_converter_clear_n,
    input wire [WIDTH-1:0] i_pressure_count,
    input wire [WIDTH-1:0] i_temperature_count,
    output reg o_sda_out,
    output reg o_sda_oe,
    output wire o_busy,
    output wire o_power_down
);
    // One-hot states of the bus engine.
    localparam [4:0] S_IDLE = 5'h01; // Not addressed, waits for START.
    localparam [4:0] S_RX = 5'h02; // Receiving a byte.
    localparam [4:0] S_ACK = 5'h04; // Driving our acknowledge.
    localparam [4:0] S_TX = 5'h08; // Sending a result byte.
    localparam [4:0] S_MACK = 5'h10; // Sampling the host acknowledge.

    // Two-stage synchronisers for the four pins, plus one more stage
    // that only the edge detectors read.
    reg [3:0] sync1; // First stage, read by sync2 alone.
    reg [3:0] sync2; // Second stage, safe to use.
    reg [2:0] prev; // Last value of scl, sda, mclk for edge detection.

    wire scl = sync2[0];
    wire sda = sync2[1];
    wire mclk = sync2[2];
    wire clear_n = sync2[3];
    wire scl_rise = scl & ~prev[0];
    wire scl_fall = ~scl & prev[0];
    // START and STOP are SDA edges while SCL stays high.
    wire bus_start = scl & prev[0] & ~sda & prev[1];
    wire bus_stop = scl & prev[0] & sda & ~prev[1];
    // The master clock is sampled like any pin; its edges pace the
    // conversion. It may stop in standby, which only pauses counting.
    wire mclk_rise = mclk & ~prev[2];

    reg [4:0] state; // Bus engine state.
    reg [3:0] bit_count; // Bits received or sent in this byte.
    reg [7:0] shift; // Receive or transmit shift register.
    reg is_addr; // Next complete byte is the address byte.
    reg read_mode; // Addressed for reading.
    reg [1:0] write_index; // Command bytes taken since the address.
    reg prefix_seen; // First command byte was all ones.
    reg select_valid; // A valid select byte waits for STOP.
    reg select_temp; // Stored selection: temperature when set.
    reg low_sent; // The low result byte has been loaded.
    reg host_ack; // Host acknowledged the last result byte.
    reg conv_start; // One-cycle command to the sequencer.

    wire [WIDTH-1:0] result;
    wire conv_busy;

    // Pin synchronisers and edge history.
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync1 <= 4'hf;
            sync2 <= 4'hf;
            prev <= 3'h7;
        end else begin
            sync1 <= {i_converter_clear_n, i_mclk, i_sda, i_scl};
            sync2 <= sync1;
            prev <= sync2[2:0];
        end
    end

    // Bus engine. START and STOP win over any bit activity, so a host
    // that aborts mid-byte always leaves the target in a known state.
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= S_IDLE;
            bit_count <= 4'h0;
            shift <= 8'h00;
            is_addr <= 1'b0;
            read_mode <= 1'b0;
            write_index <= 2'h0;
            prefix_seen <= 1'b0;
            select_valid <= 1'b0;
            select_temp <= 1'b0;
            low_sent <= 1'b0;
            host_ack <= 1'b0;
            conv_start <= 1'b0;
            o_sda_out <= 1'b0;
            o_sda_oe <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            o_sda_out <= 1'b0; // Open drain: only ever pulls low.
            if (bus_start) begin
                // START or repeated START: expect an address byte.
                state <= S_RX;
                bit_count <= 4'h0;
                is_addr <= 1'b1;
                write_index <= 2'h0;
                prefix_seen <= 1'b0;
                o_sda_oe <= 1'b0;
            end else if (bus_stop) begin
                // The select is acted on only at STOP, as the sequence
                // is complete only then.
                if (select_valid) begin
                    conv_start <= 1'b1;
                end
                select_valid <= 1'b0;
                state <= S_IDLE;
                o_sda_oe <= 1'b0;
            end else begin
                case (state)
                S_RX: begin
                    if (scl_rise) begin
                        shift <= {shift[6:0], sda};
                        bit_count <= bit_count + 4'h1;
                    end else if (scl_fall &&
                        bit_count == `BRI_BYTE_BITS) begin
                        bit_count <= 4'h0;
                        if (is_addr) begin
                            is_addr <= 1'b0;
                            read_mode <= shift[0];
                            low_sent <= 1'b0;
                            if (shift == `BRI_ADDR_WR ||
                                shift == `BRI_ADDR_RD) begin
                                state <= S_ACK;
                                o_sda_oe <= 1'b1;
                            end else begin
                                // Another target: stay off the bus.
                                state <= S_IDLE;
                            end
                        end else begin
                            write_index <= write_index + 2'h1;
                            if (write_index == 2'h0 &&
                                shift == `BRI_CMD_PREFIX) begin
                                prefix_seen <= 1'b1;
                                state <= S_ACK;
                                o_sda_oe <= 1'b1;
                            end else if (write_index == 2'h0 &&
                                shift == `BRI_CMD_READBACK) begin
                                state <= S_ACK;
                                o_sda_oe <= 1'b1;
                            end else if (write_index == 2'h1 &&
                                prefix_seen &&
                                (shift == `BRI_SEL_PRESSURE ||
                                shift == `BRI_SEL_TEMPERATURE)) begin
                                select_valid <= 1'b1;
                                select_temp <= (shift ==
                                    `BRI_SEL_TEMPERATURE);
                                state <= S_ACK;
                                o_sda_oe <= 1'b1;
                            end else begin
                                // Unknown byte: not acknowledged.
                                state <= S_IDLE;
                            end
                        end
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        bit_count <= 4'h0;
                        if (read_mode) begin
                            // High byte first, MSB on the line at once.
                            shift <= result[`BRI_HI_MSB:`BRI_HI_LSB];
                            o_sda_oe <= ~result[`BRI_HI_MSB];
                            state <= S_TX;
                        end else begin
                            o_sda_oe <= 1'b0;
                            state <= S_RX;
                        end
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        if (bit_count == `BRI_LAST_TX_BIT) begin
                            // Byte done: free the line for the host.
                            o_sda_oe <= 1'b0;
                            state <= S_MACK;
                        end else begin
                            bit_count <= bit_count + 4'h1;
                            shift <= {shift[6:0], 1'b0};
                            o_sda_oe <= ~shift[6];
                        end
                    end
                end
                S_MACK: begin
                    if (scl_rise) begin
                        host_ack <= ~sda;
                    end else if (scl_fall) begin
                        bit_count <= 4'h0;
                        if (host_ack && !low_sent) begin
                            // Host took the high byte; send the low.
                            low_sent <= 1'b1;
                            shift <= result[`BRI_LO_MSB:`BRI_LO_LSB];
                            o_sda_oe <= ~result[`BRI_LO_MSB];
                            state <= S_TX;
                        end else begin
                            // No acknowledge, or both bytes sent.
                            state <= S_IDLE;
                        end
                    end
                end
                S_IDLE: begin
                    o_sda_oe <= 1'b0;
                end
                default: begin
                    state <= S_IDLE;
                    o_sda_oe <= 1'b0;
                end
                endcase
            end
        end
    end

    // Conversion sequencer; it holds the last result until replaced.
    bri_conv #(
        .WIDTH(WIDTH),
        .CONV_EDGES(CONV_EDGES)
    ) u_conv (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_mclk_rise(mclk_rise),
        .i_clear_n(clear_n),
        .i_start(conv_start),
        .i_select_temp(select_temp),
        .i_pressure_sample(i_pressure_count),
        .i_temperature_sample(i_temperature_count),
        .o_result(result),
        .o_busy(conv_busy),
        .o_power_down(o_power_down)
    );

    assign o_busy = conv_busy;
endmodule // bri_readout

// ===== dv/bri_readout_sva.sv
/* Port checker for the barometer readout.
   Bound into bri_readout; one clock domain, raw pins seen. */
`timescale 1ns/1ps
`include "bri_readout_map.vh"
module bri_readout_sva #(
    parameter WIDTH = 16,
    parameter CONV_EDGES = `BRI_CONV_EDGES
) (
    input wire i_clk,
    input wire i_resetn,
    input wire i_scl,
    input wire i_sda,
    input wire i_mclk,
    input wire i_converter_clear_n,
    input wire [WIDTH-1:0] i_pressure_count,
    input wire [WIDTH-1:0] i_temperature_count,
    input wire o_sda_out,
    input wire o_sda_oe,
    input wire o_busy,
    input wire o_power_down
);
    reg mclk_q; // Last master clock level.
    reg sda_q; // Last data line level.
    reg [15:0] edges; // Master clock rises while busy.
    reg [3:0] stop_age; // Cycles since a STOP, saturating.
    // Pins are raw here, so the counts allow one edge of slack.
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mclk_q <= 1'b0;
            sda_q <= 1'b1;
            edges <= 16'h0000;
            stop_age <= 4'hf;
        end else begin
            mclk_q <= i_mclk;
            sda_q <= i_sda;
            if (!o_busy) begin
                edges <= 16'h0000;
            end else if (i_mclk && !mclk_q) begin
                edges <= edges + 16'h0001;
            end
            if (i_scl && i_sda && !sda_q) begin
                stop_age <= 4'h0;
            end else if (stop_age != 4'hf) begin
                stop_age <= stop_age + 4'h1;
            end
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // One host clock pulse: a rise, then a fall.
    sequence s_pulse;
        ##[1:40] $rose(i_scl) ##[1:40] $fell(i_scl);
    endsequence
    a_sda_out_low: assert property (o_sda_out == 1'b0)
        else $error("sda_out not low");
    a_pd_idle: assert property (o_power_down == !o_busy)
        else $error("power_down not inverse of busy");
    a_clear_stops: assert property (!i_converter_clear_n [*6]
        |-> !o_busy) else $error("busy while clear low");
    a_busy_clear: assert property ($rose(o_busy)
        |-> i_converter_clear_n) else $error("start under clear");
    a_oe_scl_low: assert property ($changed(o_sda_oe)
        |-> !i_scl) else $error("oe moved with scl high");
    a_oe_holds: assert property ($rose(o_sda_oe)
        |-> o_sda_oe throughout s_pulse) else $error("oe dropped early");
    a_conv_len: assert property ($fell(o_busy) && i_converter_clear_n
        |-> edges >= CONV_EDGES - 1 && edges <= CONV_EDGES + 1)
        else $error("conversion length wrong");
    a_stop_starts: assert property ($rose(o_busy)
        |-> stop_age <= 4'h8) else $error("busy without stop");
endmodule // bri_readout_sva
bind bri_readout bri_readout_sva #(.WIDTH(WIDTH), .CONV_EDGES(CONV_EDGES))
    u_bri_readout_sva (.i_clk(i_clk), .i_resetn(i_resetn), .i_scl(i_scl),
    .i_sda(i_sda), .i_mclk(i_mclk),
    .i_converter_clear_n(i_converter_clear_n),
    .i_pressure_count(i_pressure_count),
    .i_temperature_count(i_temperature_count), .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe), .o_busy(o_busy), .o_power_down(o_power_down));

// ===== dv/bri_host_model.sv
/* Host model: I2C bus master and the master clock source.
   Assumes the bench resolves SDA with a pull-up. */
`timescale 1ns/1ps
module bri_host_model #(
    parameter HALF = 8
) (
    input wire i_clk,
    input wire i_sda,
    input wire i_mclk_en,
    output reg o_scl,
    output reg o_sda_low,
    output reg o_mclk
);
    reg [2:0] div; // Eight clocks per master clock half period.
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
        o_mclk = 1'b0;
        div = 3'h0;
    end
    // A 160 ns clock while enabled; held low in standby.
    always @(posedge i_clk) begin
        div <= div + 3'h1;
        if (!i_mclk_en) begin
            o_mclk <= 1'b0;
        end else if (div == 3'h7) begin
            o_mclk <= !o_mclk;
        end
    end
    task hold;
        repeat (HALF) @(posedge i_clk);
    endtask
    // Data falls with the clock high; also serves as repeated START.
    task bus_start;
        o_sda_low <= 1'b0;
        hold;
        o_scl <= 1'b1;
        hold;
        o_sda_low <= 1'b1;
        hold;
        o_scl <= 1'b0;
        hold;
    endtask
    // Data rises with the clock high.
    task bus_stop;
        o_sda_low <= 1'b1;
        hold;
        o_scl <= 1'b1;
        hold;
        o_sda_low <= 1'b0;
        hold;
    endtask
    // A drive of one releases the line, so seen shows the target too.
    task clock_bit(input drive, output seen);
        o_sda_low <= !drive;
        hold;
        o_scl <= 1'b1;
        hold;
        seen = i_sda;
        hold;
        o_scl <= 1'b0;
        hold;
    endtask
    task wr_byte(input [7:0] b, output ack);
        integer i;
        reg d;
        for (i = 7; i >= 0; i = i - 1) begin
            clock_bit(b[i], d);
        end
        clock_bit(1'b1, ack);
    endtask
    // The last byte is refused so the target lets go of the line.
    task rd_byte(input last, output [7:0] d);
        integer i;
        reg x;
        for (i = 7; i >= 0; i = i - 1) begin
            clock_bit(1'b1, d[i]);
        end
        clock_bit(last, x);
    endtask
endmodule // bri_host_model

// ===== dv/tb_bri_readout.sv
/* Self-checking bench for the barometer readout.
   Assumes the host model and the bound checker are compiled with it. */
`timescale 1ns/1ps
`include "bri_readout_map.vh"
module tb_bri_readout;
    reg clk = 1'b0; // System clock, 100 MHz.
    reg resetn = 1'b0; // Active low reset.
    reg clear_n = 1'b0; // Converter clear, held low when idle.
    reg mclk_en = 1'b0; // Master clock runs only for conversions.
    reg [15:0] p_cnt = 16'hc381; // Pressure sample.
    reg [15:0] t_cnt = 16'h1e07; // Temperature sample.
    wire scl, host_low, mclk, sda_out, sda_oe, busy, pd;
    wire sda = !(host_low || sda_oe); // Pull-up on the open drain line.
    integer mismatches = 0;
    integer check_count = 0;
    integer cycles = 0;
    always #5 clk = !clk;
    // A short conversion keeps the run brief.
    bri_readout #(.WIDTH(16), .CONV_EDGES(4)) u_bri_readout (.i_clk(clk),
        .i_resetn(resetn), .i_scl(scl), .i_sda(sda), .i_mclk(mclk),
        .i_converter_clear_n(clear_n), .i_pressure_count(p_cnt),
        .i_temperature_count(t_cnt), .o_sda_out(sda_out),
        .o_sda_oe(sda_oe), .o_busy(busy), .o_power_down(pd));
    bri_host_model u_bri_host_model (.i_clk(clk), .i_sda(sda),
        .i_mclk_en(mclk_en), .o_scl(scl), .o_sda_low(host_low),
        .o_mclk(mclk));
    task check(input string what, input [15:0] seen, input [15:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task do_select(input [7:0] sel, output [2:0] a);
        u_bri_host_model.bus_start;
        u_bri_host_model.wr_byte(`BRI_ADDR_WR, a[2]);
        u_bri_host_model.wr_byte(`BRI_CMD_PREFIX, a[1]);
        u_bri_host_model.wr_byte(sel, a[0]);
        u_bri_host_model.bus_stop;
    endtask
    task do_read(output [15:0] r, output [2:0] a);
        u_bri_host_model.bus_start;
        u_bri_host_model.wr_byte(`BRI_ADDR_WR, a[2]);
        u_bri_host_model.wr_byte(`BRI_CMD_READBACK, a[1]);
        u_bri_host_model.bus_start;
        u_bri_host_model.wr_byte(`BRI_ADDR_RD, a[0]);
        u_bri_host_model.rd_byte(1'b0, r[15:8]);
        u_bri_host_model.rd_byte(1'b1, r[7:0]);
        u_bri_host_model.bus_stop;
    endtask
    // Before any conversion the result is the reset value; the host
    // reads it once and checks that it is zero.
    task t_first;
        reg [2:0] a;
        reg [15:0] r;
        do_read(r, a);
        check("first acks", {13'h0000, a}, 16'h0000);
        check("first read", r, 16'h0000);
        $display("test first read done");
    endtask
    // A foreign address and a bad select byte are both refused.
    task t_refuse;
        reg a;
        reg b;
        clear_n <= 1'b1;
        u_bri_host_model.bus_start;
        u_bri_host_model.wr_byte(8'hec, a);
        u_bri_host_model.bus_stop;
        check("foreign addr", {15'h0000, a}, 16'h0001);
        u_bri_host_model.bus_start;
        u_bri_host_model.wr_byte(`BRI_ADDR_WR, a);
        u_bri_host_model.wr_byte(`BRI_CMD_PREFIX, a);
        u_bri_host_model.wr_byte(8'hf1, b);
        u_bri_host_model.bus_stop;
        check("bad select", {14'h0000, b, busy}, 16'h0002);
        clear_n <= 1'b0;
        $display("test refuse done");
    endtask
    // Full select, wait and readback of one conversion kind.
    task t_convert(input [7:0] sel, input [15:0] exp);
        reg [2:0] a;
        reg [15:0] r;
        integer n;
        clear_n <= 1'b1;
        mclk_en <= 1'b1;
        do_select(sel, a);
        check("select acks", {13'h0000, a}, 16'h0000);
        check("running", {13'h0000, sda_oe, busy, pd}, 16'h0002);
        n = 0;
        while (busy !== 1'b0 && n < 500) begin
            @(posedge clk);
            n = n + 1;
        end
        check("done", {13'h0000, sda_oe, busy, pd}, 16'h0001);
        clear_n <= 1'b0;
        mclk_en <= 1'b0;
        repeat (40) @(posedge clk);
        do_read(r, a);
        check("read acks", {13'h0000, a}, 16'h0000);
        check("result", r, exp);
        $display("test convert %h done", sel);
    endtask
    // Clear mid-conversion stops it and leaves the old result.
    task t_abort;
        reg [2:0] a;
        reg [15:0] r;
        t_cnt <= 16'h7777;
        clear_n <= 1'b1;
        mclk_en <= 1'b1;
        do_select(`BRI_SEL_TEMPERATURE, a);
        clear_n <= 1'b0;
        mclk_en <= 1'b0;
        repeat (10) @(posedge clk);
        check("aborted", {13'h0000, sda_oe, busy, pd}, 16'h0001);
        do_read(r, a);
        check("kept", r, 16'h1e07);
        $display("test abort done");
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // A hang is cut short well past the expected run time.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches = mismatches + 1;
            final_report;
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        check("reset", {13'h0000, sda_oe, busy, pd}, 16'h0001);
        t_first;
        t_refuse;
        t_convert(`BRI_SEL_PRESSURE, 16'hc381);
        t_convert(`BRI_SEL_TEMPERATURE, 16'h1e07);
        t_abort;
        final_report;
    end
endmodule // tb_bri_readout
